/* File: core/pex_dispatch.sv */
// Privileged memory access decode, exception return and exception dispatch
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps

// Summary of operation
// - Opcode 27 is privileged load, 31 privileged store, normal register fields.
// - Address is sext displacement plus RB, low two bits cleared, bit 2 if quad.
// - Displacement field is a signed twelve-bit byte offset.
// - Real select clear means virtual, translated; set means physical address.
// - Virtual checks use status mode, or substitute mode when other select set.
// - Real and other select both set give physical load-locked/store-conditional.
// - Read-plus-write probe on virtual load asks both permission checks.
// - Length is quadword when eight-byte bit set, else longword.
// - Opcode 30 is the return-from-exception instruction.
// - Return loads fetch pointer from return address with two low bits zero.
// - Return sets privileged state from bit 0 of return address.
// - Bits 15..14 are hints; return address pushed on return stack.
// - Exception drains pipeline, saves PC, then dispatches.
// - Drain waits for register writers, in-flight work that may still fault, and fills.
// - Pending exceptions taken in fixed priority, reset first, float-off last.
// - Handler address bits 13..0 from entry, 33..14 from handler base.
// - Entry offsets fixed per cause as hexadecimal constants, except D-stream (ds_off from the fault) and system call.
// - System call picks one of 128 entries; bit7 low outside kernel is illegal.
// - Float-off entry on disabled unit, infinite rounding or bad datatype.
// - Corrected errors use interrupt entry; uncorrected use machine check.
// - Privileged instructions fault outside privileged state unless enabled in kernel.
// - System call saves the address of the following instruction.
module pex_dispatch
  import pex_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input pex_issue_t issue,
  input pex_fault_t fault,
  input pex_drain_t drain,
  output pex_mem_req_t mem_req,
  output pex_redirect_t redirect,
  output pex_ras_t ras,
  output logic cancel_younger,
  output logic privileged_code_state
);

  pex_state_t s;
  pex_state_t next_s;

  // Decode results, shared with the checks below
  logic take;
  logic [5:0] opc;
  logic op_priv;
  logic priv_ok;
  logic kernel;
  logic bad_priv;
  logic call;
  logic call_bad;
  logic fp_off;
  logic [9:1] vec;
  logic [3:0] rank;
  logic [13:0] entry;
  logic [33:0] ret_pc;
  logic [33:0] ea;
  logic drained;
  logic bus_sel;

  // Unused by this slave: only whole-word transfers reach it
  logic unused_size;
  assign unused_size = |hsize;

  // Zero-wait slave that always answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign mem_req = s.mreq;
  assign redirect = s.redir;
  assign ras = s.ras;
  assign privileged_code_state = s.priv;
  // Younger work is squashed from detection until the handler is entered
  assign cancel_younger = (s.fsm != PEX_RUN) || (rank != RANK_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux, sampled in the address phase
  function automatic logic [31:0] rd_word(input logic [7:0] a, input pex_state_t st);
    logic [31:0] w;
    w = 32'h0;
    if (a == REG_CTRL) begin
      w = {26'h0, st.sub_mode, st.cur_mode, st.fp_en, st.hw_en};
    end else if (a == REG_BASE) begin
      w = {12'h0, st.base};
    end else if (a == REG_ERA_LO) begin
      w = st.era[31:0];
    end else if (a == REG_ERA_HI) begin
      w = {30'h0, st.era[33:32]};
    end else if (a == REG_STATUS) begin
      // Bits 15..3 read as zero; state code sits just above the privilege bit
      w = {2'h0, st.last_entry, 13'h0, st.fsm, st.priv};
    end else if (a == REG_FETCH) begin
      w = st.fetch[31:0];
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_s = s;
    next_s.mreq.valid = 1'b0;
    next_s.redir.valid = 1'b0;
    next_s.ras.push = 1'b0;
    next_s.ras.pop = 1'b0;
    next_s.boot = 1'b0;

    // Instruction decode
    opc = issue.word[31:26];
    take = issue.valid && (s.fsm == PEX_RUN);
    kernel = (s.cur_mode == MODE_KERNEL);
    op_priv = (opc == OPC_PRIV_LOAD) || (opc == OPC_PRIV_STORE) ||
              (opc == OPC_EXC_RETURN) || (opc == OPC_REG_READ) ||
              (opc == OPC_REG_WRITE);
    priv_ok = s.priv || (s.hw_en && kernel);
    bad_priv = take && op_priv && !priv_ok;
    call = take && (opc == OPC_SYS_CALL);
    // Only 0x00-0x3f and 0x80-0xbf have entries; the low half needs kernel
    call_bad = (issue.word[25:8] != 18'h0) || issue.word[6] ||
               (!issue.word[7] && !kernel);
    fp_off = take && (opc[5:2] == OPC_FP_GROUP) &&
             (!s.fp_en || ((opc == OPC_FP_IEEE) &&
              (issue.word[11] || (issue.word[10:9] == 2'h1))));

    // Pending causes in priority order, index 1 most urgent
    vec[1] = fault.machine_check_entry;
    vec[2] = fault.math;
    vec[3] = fault.intr || fault.corr_err;
    vec[4] = fault.dstream;
    vec[5] = fault.instr_tlb_miss_entry;
    vec[6] = fault.instr_access_violation_entry;
    vec[7] = call && !call_bad;
    vec[8] = bad_priv || (call && call_bad);
    vec[9] = fp_off;
    rank = RANK_NONE;
    for (int i = 9; i >= 1; i--) begin
      if (vec[i]) begin
        rank = 4'(i);
      end
    end

    // Entry offset for the winning cause
    case (rank)
      4'h1: entry = ENTRY_MACHINE_CHECK_ENTRY;
      4'h2: entry = ENTRY_MATH;
      4'h3: entry = ENTRY_INTR;
      4'h4: entry = fault.ds_off;
      4'h5: entry = ENTRY_INSTR_TLB_MISS_ENTRY;
      4'h6: entry = ENTRY_INSTR_ACCESS_VIOLATION_ENTRY;
      // Call slots are 64 bytes apart; bit 7 moves the slot up by 4 KB
      4'h7: entry = {ENTRY_CALL_HI | {1'b0, issue.word[7]}, issue.word[5:0], 6'h0};
      4'h8: entry = ENTRY_ILLEGAL;
      4'h9: entry = ENTRY_FP_OFF;
      default: entry = ENTRY_RESET;
    endcase
    // System call returns past itself; other local faults re-execute
    if (rank == 4'h7) begin
      ret_pc = issue.pc + 34'h4;
    end else if (rank >= 4'h8) begin
      ret_pc = issue.pc;
    end else begin
      ret_pc = fault.pc;
    end

    // Privileged effective address
    ea = 34'({{22{issue.word[11]}}, issue.word[11:0]} + issue.rb);
    ea[1:0] = 2'h0;
    if (issue.word[POS_QUAD]) begin
      ea[2] = 1'b0;
    end
    drained = !drain.rf_busy && !drain.may_fault && !drain.fill_busy;

    // Bus write lands in the data phase
    if (s.wr_pend) begin
      if (s.wr_addr == REG_CTRL) begin
        next_s.hw_en = hwdata[0];
        next_s.fp_en = hwdata[1];
        next_s.cur_mode = hwdata[3:2];
        next_s.sub_mode = hwdata[5:4];
      end else if (s.wr_addr == REG_BASE) begin
        next_s.base = hwdata[19:0];
      end else if (s.wr_addr == REG_ERA_LO) begin
        next_s.era[31:0] = hwdata;
      end else if (s.wr_addr == REG_ERA_HI) begin
        next_s.era[33:32] = hwdata[1:0];
      end
    end
    bus_sel = hsel && htrans[1] && hready;
    next_s.wr_pend = bus_sel && hwrite;
    if (bus_sel) begin
      next_s.wr_addr = haddr[7:0];
      next_s.rdata = hwrite ? 32'h0 : rd_word(haddr[7:0], s);
    end

    // Sequencer; hardware saves win over a software write in the same cycle
    case (s.fsm)
      PEX_RUN: begin
        if (rank != RANK_NONE) begin
          next_s.fsm = PEX_DRAIN;
          next_s.rank = rank;
          next_s.entry = entry;
          next_s.save_pc = ret_pc;
        end else if (take && (opc == OPC_PRIV_LOAD || opc == OPC_PRIV_STORE)) begin
          next_s.mreq.valid = 1'b1;
          next_s.mreq.store = (opc == OPC_PRIV_STORE);
          next_s.mreq.ra = issue.word[25:21];
          next_s.mreq.addr = ea;
          next_s.mreq.phys = issue.word[POS_REAL];
          next_s.mreq.mode = issue.word[POS_OTHER] ? s.sub_mode : s.cur_mode;
          next_s.mreq.lock = issue.word[POS_REAL] && issue.word[POS_OTHER];
          next_s.mreq.rw_check = issue.word[POS_RWC] && !issue.word[POS_REAL] &&
                                 (opc == OPC_PRIV_LOAD);
          next_s.mreq.quad = issue.word[POS_QUAD];
        end else if (take && opc == OPC_EXC_RETURN) begin
          next_s.redir.valid = 1'b1;
          next_s.redir.target = {s.era[33:2], 2'h0};
          next_s.fetch = {s.era[33:2], 2'h0};
          next_s.priv = s.era[0];
          next_s.ras.push = 1'b1;
          next_s.ras.addr = s.era;
          next_s.ras.pop = issue.word[POS_HINT_POP];
        end
      end
      PEX_DRAIN: begin
        // A more urgent outside event arriving mid-drain takes over
        if (rank != RANK_NONE && rank < s.rank) begin
          next_s.rank = rank;
          next_s.entry = entry;
          next_s.save_pc = ret_pc;
        end
        if (drained) begin
          next_s.era = next_s.save_pc;
          next_s.fsm = PEX_DISPATCH;
        end
      end
      default: begin
        next_s.redir.valid = 1'b1;
        next_s.redir.target = {s.base, s.entry};
        next_s.fetch = {s.base, s.entry};
        next_s.priv = 1'b1;
        next_s.last_entry = s.entry;
        next_s.rank = RANK_NONE;
        next_s.fsm = PEX_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset enters the reset handler from any point
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.fsm <= PEX_DISPATCH;
      s.entry <= ENTRY_RESET;
      s.rank <= RANK_RESET;
      s.base <= RST_BASE;
      s.cur_mode <= RST_MODE;
      s.sub_mode <= RST_MODE;
      s.priv <= 1'b1;
      s.boot <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence q_mem_issue(logic [5:0] code);
    take && opc == code && priv_ok && rank == RANK_NONE;
  endsequence

  sequence q_rei_issue;
    take && opc == OPC_EXC_RETURN && priv_ok && rank == RANK_NONE;
  endsequence

  property p_load_decode;
    @(posedge core_clk) disable iff (!rstn)
    q_mem_issue(OPC_PRIV_LOAD) |=> mem_req.valid && !mem_req.store
      && mem_req.quad == $past(issue.word[12]);
  endproperty
  a_load_decode: assert property (p_load_decode)
    else $error("privileged load not issued as a load");

  property p_addr_form;
    @(posedge core_clk) disable iff (!rstn)
    q_mem_issue(OPC_PRIV_STORE) |=> mem_req.store && mem_req.addr[1:0] == 2'h0
      && (!mem_req.quad || !mem_req.addr[2])
      && mem_req.addr[33:3] == $past(ea[33:3]);
  endproperty
  a_addr_form: assert property (p_addr_form)
    else $error("privileged store address wrongly formed");

  property p_mode_lock;
    @(posedge core_clk) disable iff (!rstn)
    q_mem_issue(OPC_PRIV_LOAD) ##0 (issue.word[15] && issue.word[14])
      |=> mem_req.lock && mem_req.phys && mem_req.mode == $past(s.sub_mode);
  endproperty
  a_mode_lock: assert property (p_mode_lock)
    else $error("lock variant or substitute mode missing");

  property p_return;
    @(posedge core_clk) disable iff (!rstn)
    q_rei_issue |=> redirect.valid && redirect.target == {$past(s.era[33:2]), 2'h0}
      && privileged_code_state == $past(s.era[0]) && ras.push;
  endproperty
  a_return: assert property (p_return)
    else $error("return target or privileged state wrong");

  property p_drain_wait;
    @(posedge core_clk) disable iff (!rstn)
    s.fsm == PEX_DRAIN && !drained |=> !redirect.valid && s.fsm != PEX_DISPATCH;
  endproperty
  a_drain_wait: assert property (p_drain_wait)
    else $error("dispatch before pipeline drained");

  // The entry may still be replaced in the drained cycle, so compare the one held at dispatch
  property p_save_then_go;
    @(posedge core_clk) disable iff (!rstn)
    s.fsm == PEX_DRAIN && drained |=> s.era == $past(next_s.save_pc)
      ##1 redirect.valid && redirect.target[13:0] == $past(s.entry);
  endproperty
  a_save_then_go: assert property (p_save_then_go)
    else $error("return address not saved before dispatch");

  property p_priority;
    @(posedge core_clk) disable iff (!rstn)
    s.fsm == PEX_RUN && fault.machine_check_entry |=> s.entry == ENTRY_MACHINE_CHECK_ENTRY && s.fsm == PEX_DRAIN;
  endproperty
  a_priority: assert property (p_priority)
    else $error("machine check lost priority");

  // Sampled reset keeps the release edge out: state is still held in reset there
  property p_reset_entry;
    @(posedge core_clk) disable iff (!rstn)
    rstn && s.boot |-> redirect.valid == 1'b0 ##1 redirect.valid
      && redirect.target == {s.base, ENTRY_RESET};
  endproperty
  a_reset_entry: assert property (p_reset_entry)
    else $error("reset did not enter offset zero");

  property p_reserved;
    @(posedge core_clk) disable iff (!rstn)
    bad_priv && vec[7:1] == 7'h0 |=> s.entry == ENTRY_ILLEGAL;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("privileged opcode outside privileged state not trapped");

  property p_cancel;
    @(posedge core_clk) disable iff (!rstn)
    s.fsm == PEX_DRAIN |-> cancel_younger && !mem_req.valid;
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("younger work not cancelled during drain");

endmodule

/* File: core/pex_pkg.sv */
// Constants, field layouts and carrier types of the exception dispatch block
package pex_pkg;
  // Instruction opcodes
  localparam logic [5:0] OPC_SYS_CALL = 6'h00;
  localparam logic [5:0] OPC_FP_IEEE = 6'h16;
  localparam logic [3:0] OPC_FP_GROUP = 4'h5;
  localparam logic [5:0] OPC_REG_READ = 6'h19;
  localparam logic [5:0] OPC_PRIV_LOAD = 6'h1b;
  localparam logic [5:0] OPC_REG_WRITE = 6'h1d;
  localparam logic [5:0] OPC_EXC_RETURN = 6'h1e;
  localparam logic [5:0] OPC_PRIV_STORE = 6'h1f;
  // Privileged load/store field positions
  localparam int POS_REAL = 15;
  localparam int POS_OTHER = 14;
  localparam int POS_RWC = 13;
  localparam int POS_QUAD = 12;
  localparam int POS_HINT_POP = 15;
  // Handler entry offsets, bits 13..0 of the handler address
  localparam logic [13:0] ENTRY_RESET = 14'h0000;
  localparam logic [13:0] ENTRY_MACHINE_CHECK_ENTRY = 14'h0020;
  localparam logic [13:0] ENTRY_MATH = 14'h0060;
  localparam logic [13:0] ENTRY_INTR = 14'h00e0;
  localparam logic [13:0] ENTRY_INSTR_TLB_MISS_ENTRY = 14'h03e0;
  localparam logic [13:0] ENTRY_INSTR_ACCESS_VIOLATION_ENTRY = 14'h07e0;
  localparam logic [13:0] ENTRY_ILLEGAL = 14'h13e0;
  localparam logic [13:0] ENTRY_FP_OFF = 14'h17e0;
  localparam logic [1:0] ENTRY_CALL_HI = 2'h2;
  // Priority ranks, lower is more urgent
  localparam logic [3:0] RANK_RESET = 4'h0;
  localparam logic [3:0] RANK_NONE = 4'hf;
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BASE = 8'h04;
  localparam logic [7:0] REG_ERA_LO = 8'h08;
  localparam logic [7:0] REG_ERA_HI = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_FETCH = 8'h14;
  // Values after reset
  localparam logic [19:0] RST_BASE = 20'h00000;
  localparam logic [1:0] RST_MODE = 2'h0;

  typedef enum logic [1:0] {PEX_RUN, PEX_DRAIN, PEX_DISPATCH} pex_fsm_t;

  typedef struct packed {
    logic valid;
    logic [31:0] word;
    logic [33:0] pc;
    logic [33:0] rb;
  } pex_issue_t;

  typedef struct packed {
    logic machine_check_entry;
    logic math;
    logic intr;
    logic corr_err;
    logic dstream;
    logic [13:0] ds_off;
    logic instr_tlb_miss_entry;
    logic instr_access_violation_entry;
    logic [33:0] pc;
  } pex_fault_t;

  typedef struct packed {
    logic rf_busy;
    logic may_fault;
    logic fill_busy;
  } pex_drain_t;

  typedef struct packed {
    logic valid;
    logic store;
    logic phys;
    logic lock;
    logic rw_check;
    logic quad;
    logic [1:0] mode;
    logic [4:0] ra;
    logic [33:0] addr;
  } pex_mem_req_t;

  typedef struct packed {
    logic valid;
    logic [33:0] target;
  } pex_redirect_t;

  typedef struct packed {
    logic push;
    logic pop;
    logic [33:0] addr;
  } pex_ras_t;

  typedef struct packed {
    pex_fsm_t fsm;
    logic hw_en;
    logic fp_en;
    logic [1:0] cur_mode;
    logic [1:0] sub_mode;
    logic [19:0] base;
    logic [33:0] era;
    logic priv;
    logic [3:0] rank;
    logic [13:0] entry;
    logic [33:0] save_pc;
    logic [13:0] last_entry;
    logic [33:0] fetch;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    pex_mem_req_t mreq;
    pex_redirect_t redir;
    pex_ras_t ras;
    logic boot;
  } pex_state_t;
endpackage

/* File: testbench/pex_fw_model.sv */
// Firmware-side model: issues instruction words and keeps the pipeline busy after faults
`timescale 1ns/10ps
module pex_fw_model
  import pex_pkg::*;
(
  input wire logic core_clk,
  input wire logic cancel_younger,
  output pex_issue_t issue,
  output pex_drain_t drain
);
  int busy_len = 0;
  int busy_left = 0;
  logic cancel_q = 1'b0;

  initial issue = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // In-flight writers and fills stay busy for a while, so the drain wait is exercised
  always @(posedge core_clk) begin
    cancel_q <= cancel_younger;
    if (cancel_younger && !cancel_q) begin
      busy_left <= busy_len;
    end else if (busy_left > 0) begin
      busy_left <= busy_left - 1;
    end
  end
  // Each drain condition holds the dispatch back on its own: may_fault and fill_busy for one cycle each, rf_busy for busy_len minus 2
  assign drain.rf_busy = busy_left > 2;
  assign drain.may_fault = busy_left == 2;
  assign drain.fill_busy = busy_left == 1;

  ////////////////////////////////////////////////////////////////////////////////
  // One word per call; between issues the fields carry junk, not the old word
  task automatic send(input logic [31:0] w, input logic [33:0] pc, input logic [33:0] rb);
    logic [31:0] word;
    word = w;
    if (w[31:26] == OPC_EXC_RETURN) begin
      word[15] = 1'b1;
      word[25:16] = 10'h3ff;
    end
    issue <= '{1'b1, word, pc, rb};
    @(posedge core_clk);
    issue <= '{1'b0, ~word, ~pc, ~rb};
  endtask
endmodule

/* File: testbench/pex_dispatch_tb.sv */
// Bench for the exception dispatch block: bus, issue, return and fault scenarios
`timescale 1ns/10ps
module pex_dispatch_tb
  import pex_pkg::*;
;
  localparam logic [19:0] TB_BASE = 20'h00a5c;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  pex_issue_t issue;
  pex_fault_t fault = '0;
  pex_drain_t drain;
  pex_mem_req_t mem_req;
  pex_redirect_t redirect;
  pex_ras_t ras;
  logic cancel_younger;
  logic privileged_code_state;
  pex_ras_t ras_seen = '0;
  logic mem_seen = 1'b0;
  logic [31:0] rd;
  int bad_count = 0;
  int compares = 0;
  int wait_n;
  logic [6:0] fm [10] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01, 7'h50, 7'h22, 7'h03};
  logic [13:0] fe [10] = '{14'h0020, 14'h0060, 14'h00e0, 14'h00e0, 14'h09e0, 14'h03e0,
    14'h07e0, 14'h0020, 14'h0060, 14'h03e0};

  always #4 core_clk = ~core_clk;

  pex_dispatch u_pex_dispatch (
    .core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .issue(issue), .fault(fault), .drain(drain),
    .mem_req(mem_req), .redirect(redirect), .ras(ras), .cancel_younger(cancel_younger),
    .privileged_code_state(privileged_code_state));

  pex_fw_model u_pex_fw_model (
    .core_clk(core_clk), .cancel_younger(cancel_younger), .issue(issue), .drain(drain));

  ////////////////////////////////////////////////////////////////////////////////
  // Pulses are caught at the falling edge, where they have settled
  always @(negedge core_clk) begin
    if (ras.push === 1'b1) begin
      ras_seen = ras;
    end
    if (mem_req.valid === 1'b1) begin
      mem_seen = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A wait that runs out ends the run at once, since later steps would be meaningless
  task automatic timeout(input string what);
    bad_count++;
    $display("MISMATCH %s expected done seen timeout", what);
    report_and_stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bus master: address phase held until ready, then data phase until ready
  task automatic ready_wait();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) timeout("bus ready");
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    ready_wait();
    htrans <= 2'h0;
    hwdata <= d;
    ready_wait();
    rd = hrdata;
    check("bus response", 64'h0, hresp);
  endtask

  task automatic wait_redir(input string what, input logic [33:0] tgt);
    wait_n = 0;
    do begin
      @(negedge core_clk);
      wait_n++;
    end while (redirect.valid !== 1'b1 && wait_n < 60);
    if (redirect.valid !== 1'b1) timeout(what);
    check(what, tgt, redirect.target);
    @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic do_reset();
    rstn <= 1'b0;
    fault <= '0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    wait_redir("reset target", 34'h0);
    check("priv after reset", 1, privileged_code_state);
  endtask

  task automatic mem_case(input logic [5:0] op, input logic [3:0] fl, input logic [11:0] byte_offset_field,
    input logic [33:0] rb, input logic [1:0] cm);
    logic [33:0] a;
    a = {{22{byte_offset_field[11]}}, byte_offset_field} + rb;
    a[1:0] = 2'b00;
    if (fl[0]) a[2] = 1'b0;
    u_pex_fw_model.send({op, 5'd3, 5'd7, fl, byte_offset_field}, 34'h0, rb);
    wait_n = 0;
    do begin
      @(negedge core_clk);
      wait_n++;
    end while (mem_req.valid !== 1'b1 && wait_n < 20);
    if (mem_req.valid !== 1'b1) timeout("memory request");
    check("mem request", {a, op == OPC_PRIV_STORE, fl[3], fl[3] & fl[2], fl[1], fl[0], 5'd3},
      {mem_req.addr, mem_req.store, mem_req.phys, mem_req.lock, mem_req.rw_check,
      mem_req.quad, mem_req.ra});
    if (!fl[3]) check("mem mode", fl[2] ? 2'h3 : cm, mem_req.mode);
    @(posedge core_clk);
  endtask

  task automatic t_return(input logic [33:0] era);
    ras_seen = '0;
    bus(1'b1, REG_ERA_LO, era[31:0]);
    bus(1'b1, REG_ERA_HI, {30'h0, era[33:32]});
    u_pex_fw_model.send({OPC_EXC_RETURN, 26'h0}, 34'h0, 34'h0);
    wait_redir("return target", {era[33:2], 2'b00});
    @(negedge core_clk);
    check("priv after return", era[0], privileged_code_state);
    check("return stack", {2'b11, era}, {ras_seen.push, ras_seen.pop, ras_seen.addr});
    @(posedge core_clk);
  endtask

  task automatic t_instr_fault(input logic [31:0] w, input logic [13:0] ent, input string what);
    u_pex_fw_model.send(w, 34'h2_0000_1000, 34'h0);
    wait_redir(what, {TB_BASE, ent});
  endtask

  task automatic t_fault(input logic [6:0] m, input logic [13:0] ent);
    pex_fault_t f;
    f = '0;
    f.pc = 34'h1_2345_6788;
    f.ds_off = 14'h09e0;
    {f.machine_check_entry, f.math, f.intr, f.corr_err, f.dstream, f.instr_tlb_miss_entry, f.instr_access_violation_entry} = m;
    fault <= f;
    @(negedge core_clk);
    check("cancel younger", 1, cancel_younger);
    @(posedge core_clk);
    {f.machine_check_entry, f.math, f.intr, f.corr_err, f.dstream, f.instr_tlb_miss_entry, f.instr_access_violation_entry} = 7'h0;
    fault <= f;
    wait_redir("fault target", {TB_BASE, ent});
    check("drain wait", u_pex_fw_model.busy_len + 3, wait_n);
    check("priv at entry", 1, privileged_code_state);
    bus(1'b0, REG_ERA_LO, 32'h0);
    check("saved pc low", 32'h2345_6788, rd);
    bus(1'b0, REG_ERA_HI, 32'h0);
    check("saved pc high", 32'h1, rd[1:0]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    do_reset();
    bus(1'b1, REG_BASE, {12'h0, TB_BASE});
    bus(1'b0, REG_BASE, 32'h0);
    check("handler base", {12'h0, TB_BASE}, rd);
    bus(1'b0, 8'h3c, 32'h0);
    check("unmapped read", 32'h0, rd);
    bus(1'b1, REG_STATUS, 32'hffff_ffff);
    bus(1'b0, REG_STATUS, 32'h0);
    check("status after reset", 32'h1, rd);
    bus(1'b1, REG_CTRL, 32'h34);
    mem_case(OPC_PRIV_LOAD, 4'b0000, 12'hffc, 34'h100, 2'h1);
    mem_case(OPC_PRIV_LOAD, 4'b1100, 12'h00d, 34'h200, 2'h1);
    mem_case(OPC_PRIV_LOAD, 4'b0111, 12'h7ff, 34'h1000, 2'h1);
    mem_case(OPC_PRIV_STORE, 4'b1000, 12'h800, 34'h1000, 2'h1);
    mem_case(OPC_PRIV_STORE, 4'b0101, 12'h004, 34'h3_0000_0000, 2'h1);
    t_return(34'h0_0000_4002);
    mem_seen = 1'b0;
    t_instr_fault({OPC_PRIV_LOAD, 26'h0}, 14'h13e0, "unprivileged load");
    check("no request when refused", 0, mem_seen);
    t_return(34'h1_0000_8003);
    t_return(34'h0_0000_4002);
    bus(1'b1, REG_CTRL, 32'h31);
    mem_case(OPC_PRIV_LOAD, 4'b0000, 12'h010, 34'h40, 2'h0);
    t_instr_fault({6'h00, 26'h85}, 14'h3140, "system call");
    bus(1'b0, REG_ERA_LO, 32'h0);
    check("call return address", 32'h0000_1004, rd);
    bus(1'b1, REG_CTRL, 32'h35);
    t_instr_fault({6'h00, 26'h01}, 14'h13e0, "user system call");
    t_instr_fault({OPC_FP_IEEE, 26'h0}, 14'h17e0, "float disabled");
    bus(1'b1, REG_CTRL, 32'h36);
    t_instr_fault({OPC_FP_IEEE, 26'h800}, 14'h17e0, "infinite rounding");
    t_instr_fault({OPC_FP_IEEE, 26'h200}, 14'h17e0, "bad datatype");
    u_pex_fw_model.busy_len = 3;
    for (int i = 0; i < 10; i++) begin
      t_fault(fm[i], fe[i]);
    end
    fault <= '{machine_check_entry: 1'b1, default: '0};
    @(posedge core_clk);
    do_reset();
    report_and_stop();
  end
endmodule
